// File: rtl/crce_pkg.sv
// constants and types shared by the checksum engine files
`default_nettype none
package crce_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int LEN_W = 4;
    localparam int FIFO_DEPTH = 2;
    localparam int CNT_W = 2;

    // ==========================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_LEN = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_DATA = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_ACC = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_POLY = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STAT = 4'h5;

    // ==========================================
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SCAN_BIT = 1;
    localparam int CTRL_DIR_BIT = 2;
    localparam int CTRL_AUG_BIT = 3;
    localparam int LEN_DATA_LENGTH_FIELD_LSB = 0;
    localparam int LEN_POLY_LENGTH_FIELD_LSB = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_PEND_BIT = 2;

    // ==========================================
    // reset values
    localparam logic [LEN_W-1:0] DATA_LENGTH_FIELD_RST = 4'h7;
    localparam logic [LEN_W-1:0] POLY_LENGTH_FIELD_RST = 4'hf;
    localparam logic [DATA_W-1:0] POLY_RST = 16'h0000;
    localparam logic [DATA_W-1:0] ACC_RST = 16'h0000;

    typedef enum logic [0:0] {
        ENG_IDLE = 1'b0,
        ENG_SHIFT = 1'b1
    } crce_eng_t;

    // one step of the xor feedback register; top term and constant term forced to one
    function automatic logic [DATA_W-1:0] crce_step(
        input logic [DATA_W-1:0] acc,
        input logic din,
        input logic [DATA_W-1:0] poly,
        input logic [LEN_W-1:0] poly_length_field,
        input logic aug
    );
        logic [DATA_W-1:0] wmask;
        logic [DATA_W-1:0] peff;
        logic [DATA_W-1:0] sh;
        logic msb;
        logic fb;
        wmask = 16'hffff >> (4'hf - poly_length_field);
        peff = {poly[DATA_W-1:1], 1'b1} & wmask;
        msb = acc[poly_length_field];
        fb = aug ? (msb ^ din) : msb;
        sh = aug ? {acc[DATA_W-2:0], 1'b0} : {acc[DATA_W-2:0], din};
        return (sh ^ (fb ? peff : 16'h0000)) & wmask;
    endfunction : crce_step

    function automatic logic [DATA_W-1:0] crce_mask(input logic [LEN_W-1:0] poly_length_field);
        return 16'hffff >> (4'hf - poly_length_field);
    endfunction : crce_mask
endpackage : crce_pkg
`default_nettype wire

// File: rtl/crce_fifo.sv
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module crce_fifo
    import crce_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    input wire logic [DATA_W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [DATA_W-1:0] out_data_o,
    input wire logic out_ready_i
);
    typedef struct packed {
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
        logic [CNT_W-1:0] cnt;
        logic rd_ptr;
        logic wr_ptr;
        logic in_ready;
    } crce_fifo_st_t;

    crce_fifo_st_t s_q;
    crce_fifo_st_t s_d;
    logic push;
    logic pop;

    assign push = in_valid_i & s_q.in_ready;
    assign pop = out_ready_i & (s_q.cnt != 2'h0);
    assign in_ready_o = s_q.in_ready;
    assign out_valid_o = (s_q.cnt != 2'h0);
    assign out_data_o = s_q.mem[s_q.rd_ptr];

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr_ptr] = in_data_i;
            s_d.wr_ptr = ~s_q.wr_ptr;
        end
        if (pop)
        begin
            s_d.rd_ptr = ~s_q.rd_ptr;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
        // ready is registered, so it is worked out from the next count, after this cycle's push and pop
        s_d.in_ready = (s_d.cnt != 2'h2);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '0;
            s_q.in_ready <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule : crce_fifo
`default_nettype wire

// File: rtl/crce_shifter.sv
// bit-serial polynomial divider holding the checksum accumulator
`timescale 1ns/1ps
`default_nettype none
module crce_shifter
    import crce_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic word_valid_i,
    input wire logic [DATA_W-1:0] word_i,
    output logic word_ready_o,
    input wire logic [LEN_W-1:0] data_length_field_i,
    input wire logic [LEN_W-1:0] poly_length_field_i,
    input wire logic [DATA_W-1:0] poly_i,
    input wire logic dir_lsb_first_i,
    input wire logic aug_auto_i,
    input wire logic seed_load_i,
    input wire logic [DATA_W-1:0] seed_i,
    output logic [DATA_W-1:0] acc_o,
    output logic busy_o
);
    typedef struct packed {
        crce_eng_t st;
        logic [DATA_W-1:0] acc;
        logic [DATA_W-1:0] sh;
        logic [LEN_W-1:0] left;
        logic dir;
    } crce_sh_st_t;

    crce_sh_st_t s_q;
    crce_sh_st_t s_d;
    logic din;

    assign word_ready_o = enable_i & (s_q.st == ENG_IDLE);
    assign acc_o = s_q.acc;
    assign busy_o = (s_q.st == ENG_SHIFT);
    assign din = s_q.dir ? s_q.sh[0] : s_q.sh[data_length_field_i];  // [RL10]

    always_comb
    begin
        s_d = s_q;
        unique case (s_q.st)
            ENG_IDLE:
            begin
                if (seed_load_i)
                begin
                    s_d.acc = seed_i & crce_mask(poly_length_field_i);  // [RL2]
                end
                else if (word_valid_i && enable_i)
                begin
                    s_d.sh = word_i;
                    s_d.left = data_length_field_i;  // [RL13]
                    s_d.dir = dir_lsb_first_i;
                    s_d.st = ENG_SHIFT;
                end
            end
            ENG_SHIFT:
            begin
                // one data bit per clock through the xor feedback register
                s_d.acc = crce_step(s_q.acc, din, poly_i, poly_length_field_i, aug_auto_i);  // [RL4] [RL11]
                s_d.sh = s_q.dir ? (s_q.sh >> 1) : (s_q.sh << 1);
                s_d.left = s_q.left - 4'h1;
                if (s_q.left == 4'h0)
                begin
                    s_d.st = ENG_IDLE;  // [RL13]
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '0;
            s_q.acc <= ACC_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule : crce_shifter
`default_nettype wire

// File: rtl/crce_top.sv
// checksum engine top: register port, word source select, buffer and shifter
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RL1] any generator polynomial up to degree 16 can be used
// [RL2] software loads a seed of up to 16 bits before calculating
// [RL3] the result sits in a 16-bit accumulator readable by software
// [RL4] division by an xor feedback shift register, one bit per step
// [RL5] 4-bit polynomial length field sets the polynomial degree
// [RL6] top and constant polynomial terms are always treated as ones
// [RL7] polynomial register stores bits 15..1; bit 0 reads zero
// [RL8] words from the memory scanner are taken without processor writes
// [RL9] without the scanner, each processor data write is one processed word; a data write while the buffer is full is dropped
// [RL10] shift direction picks msb-first or lsb-first data entry
// [RL11] augment mode: zeros appended by hardware or fed by software
// [RL12] polynomial sits in bits 15..1 in non-reflected form
// [RL13] 4-bit data length field is word width minus one
module crce_top
    import crce_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic scan_valid_i,
    input wire logic [DATA_W-1:0] scan_data_i,
    output logic scan_ready_o,
    output logic busy_o
);
    // ==========================================
    // state
    typedef struct packed {
        logic enable;
        logic scan_sel;
        logic dir;
        logic aug;
        logic [LEN_W-1:0] data_length_field;
        logic [LEN_W-1:0] poly_length_field;
        logic [DATA_W-1:1] poly;
        logic [DATA_W-1:0] rd_data;
        logic busy;
    } crce_top_st_t;

    crce_top_st_t s_q;
    crce_top_st_t s_d;

    logic fifo_in_valid;
    logic [DATA_W-1:0] fifo_in_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic fifo_out_ready;
    logic [DATA_W-1:0] acc;
    logic eng_busy;
    logic seed_load;
    logic wr_data_reg;

    // ==========================================
    // word source
    // the scanner and the data register share one buffer; only the selected one pushes
    assign wr_data_reg = wr_i & (addr_i == OFF_DATA);
    assign fifo_in_valid = s_q.scan_sel ? scan_valid_i : wr_data_reg;  // [RL8] [RL9]
    assign fifo_in_data = s_q.scan_sel ? scan_data_i : wr_data_i;
    // seed only lands while idle; a write during a word is dropped
    assign seed_load = wr_i & (addr_i == OFF_ACC) & ~eng_busy & ~fifo_out_valid;  // [RL2]

    crce_fifo u_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(fifo_in_valid),
        .in_data_i(fifo_in_data),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(fifo_out_ready)
    );

    crce_shifter u_shifter (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .enable_i(s_q.enable),
        .word_valid_i(fifo_out_valid),
        .word_i(fifo_out_data),
        .word_ready_o(fifo_out_ready),
        .data_length_field_i(s_q.data_length_field),
        .poly_length_field_i(s_q.poly_length_field),  // [RL1] [RL5]
        .poly_i({s_q.poly, 1'b1}),  // [RL6]
        .dir_lsb_first_i(s_q.dir),
        .aug_auto_i(s_q.aug),
        .seed_load_i(seed_load),
        .seed_i(wr_data_i),
        .acc_o(acc),
        .busy_o(eng_busy)
    );

    // scanner ready mirrors the buffer's registered space flag
    assign scan_ready_o = fifo_in_ready;
    assign rd_data_o = s_q.rd_data;
    assign busy_o = s_q.busy;

    // ==========================================
    // registers
    always_comb
    begin
        s_d = s_q;
        s_d.busy = eng_busy | fifo_out_valid | (fifo_in_valid & fifo_in_ready);
        s_d.rd_data = 16'h0000;
        if (wr_i)
        begin
            unique case (addr_i)
                OFF_CTRL:
                begin
                    s_d.enable = wr_data_i[CTRL_EN_BIT];
                    s_d.scan_sel = wr_data_i[CTRL_SCAN_BIT];
                    s_d.dir = wr_data_i[CTRL_DIR_BIT];  // [RL10]
                    s_d.aug = wr_data_i[CTRL_AUG_BIT];  // [RL11]
                end
                OFF_LEN:
                begin
                    s_d.data_length_field = wr_data_i[LEN_DATA_LENGTH_FIELD_LSB +: LEN_W];  // [RL13]
                    s_d.poly_length_field = wr_data_i[LEN_POLY_LENGTH_FIELD_LSB +: LEN_W];  // [RL5]
                end
                OFF_POLY:
                begin
                    s_d.poly = wr_data_i[DATA_W-1:1];  // [RL7] [RL12]
                end
                default:
                begin
                end
            endcase
        end
        if (rd_i)
        begin
            unique case (addr_i)
                OFF_CTRL:
                begin
                    s_d.rd_data[CTRL_EN_BIT] = s_q.enable;
                    s_d.rd_data[CTRL_SCAN_BIT] = s_q.scan_sel;
                    s_d.rd_data[CTRL_DIR_BIT] = s_q.dir;
                    s_d.rd_data[CTRL_AUG_BIT] = s_q.aug;
                end
                OFF_LEN:
                begin
                    s_d.rd_data[LEN_DATA_LENGTH_FIELD_LSB +: LEN_W] = s_q.data_length_field;
                    s_d.rd_data[LEN_POLY_LENGTH_FIELD_LSB +: LEN_W] = s_q.poly_length_field;
                end
                OFF_ACC:
                begin
                    s_d.rd_data = acc;  // [RL3]
                end
                OFF_POLY:
                begin
                    s_d.rd_data = {s_q.poly, 1'b0};  // [RL7]
                end
                OFF_STAT:
                begin
                    s_d.rd_data[STAT_BUSY_BIT] = eng_busy;
                    s_d.rd_data[STAT_FULL_BIT] = ~fifo_in_ready;
                    s_d.rd_data[STAT_PEND_BIT] = fifo_out_valid;
                end
                default:
                begin
                    s_d.rd_data = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_q <= '0;
            s_q.data_length_field <= DATA_LENGTH_FIELD_RST;
            s_q.poly_length_field <= POLY_LENGTH_FIELD_RST;
            s_q.poly <= POLY_RST[DATA_W-1:1];
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule : crce_top
`default_nettype wire

// File: dv/crce_properties.sv
// port-level assertions for the checksum engine
`timescale 1ns/1ps
`default_nettype none
module crce_checker
    import crce_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic scan_valid_i,
    input wire logic [DATA_W-1:0] scan_data_i,
    input wire logic scan_ready_o,
    input wire logic busy_o
);
    logic en_q;
    logic sel_q;
    logic push;
    logic [DATA_W-1:0] poly_q;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // push counts ignored writes too: it only bounds where a fall may come from
    assign push = (scan_valid_i && scan_ready_o && sel_q) || (wr_i && addr_i == OFF_DATA);
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            en_q <= 1'b0;
            sel_q <= 1'b0;
            poly_q <= POLY_RST;
        end
        else if (wr_i && addr_i == OFF_CTRL)
        begin
            en_q <= wr_data_i[CTRL_EN_BIT];
            sel_q <= wr_data_i[CTRL_SCAN_BIT];
        end
        else if (wr_i && addr_i == OFF_POLY)
            poly_q <= wr_data_i;
    end
    property p_rd_idle;
        !rd_i |=> rd_data_o == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    property p_unmapped;
        rd_i && addr_i > OFF_STAT |=> rd_data_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_poly_bit0;
        rd_i && addr_i == OFF_POLY |=> !rd_data_o[0];
    endproperty
    a_poly_bit0: assert property (p_poly_bit0) else $error("poly bit0 set");
    property p_poly_back;
        rd_i && addr_i == OFF_POLY |=> rd_data_o == ($past(poly_q) & 16'hfffe);
    endproperty
    a_poly_back: assert property (p_poly_back) else $error("poly readback");
    property p_scan_start;
        scan_valid_i && scan_ready_o && sel_q && en_q |-> ##[1:3] busy_o;
    endproperty
    a_scan_start: assert property (p_scan_start) else $error("scan word not run");
    property p_data_start;
        wr_i && addr_i == OFF_DATA && en_q && !sel_q && scan_ready_o && !busy_o
            |-> ##[1:3] busy_o;
    endproperty
    a_data_start: assert property (p_data_start) else $error("data word not run");
    property p_ready_fall;
        $fell(scan_ready_o) |-> $past(push) || $past(push, 2);
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready fell alone");
    property p_ready_rise;
        $rose(scan_ready_o) |-> ##[0:2] busy_o;
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready rose idle");
endmodule : crce_checker
bind crce_top crce_checker u_checker (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .scan_valid_i(scan_valid_i), .scan_data_i(scan_data_i), .scan_ready_o(scan_ready_o),
    .busy_o(busy_o));
`default_nettype wire

// File: dv/crce_scan_model.sv
// memory scanner model: queued words, optional gap between them
`timescale 1ns/1ps
`default_nettype none
module crce_scan_model
    import crce_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic push_i,
    input wire logic [DATA_W-1:0] word_i,
    input wire logic [3:0] gap_i,
    input wire logic sel_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [DATA_W-1:0] data_o
);
    logic [DATA_W-1:0] q[$];
    int wait_n;
    always @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            q.delete();
            valid_o <= 1'b0;
            data_o <= 16'h0000;
            wait_n = 0;
        end
        else
        begin
            if (push_i)
                q.push_back(word_i);
            if (valid_o && ready_i && sel_i)
            begin
                valid_o <= 1'b0;
                // released bus shows inverse, never the stale word
                data_o <= ~data_o;
                wait_n = gap_i;
            end
            else if (!valid_o && wait_n > 0)
                wait_n--;
            else if (!valid_o && q.size() > 0)
            begin
                valid_o <= 1'b1;
                data_o <= q.pop_front();
            end
        end
    end
endmodule : crce_scan_model
`default_nettype wire

// File: dv/crce_top_test.sv
// self-checking bench for the checksum engine
`timescale 1ns/1ps
`default_nettype none
module crce_top_test import crce_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = 4'h0;
    logic [DATA_W-1:0] wr_data_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DATA_W-1:0] rd_data_o;
    logic scan_valid_i;
    logic [DATA_W-1:0] scan_data_i;
    logic scan_ready_o;
    logic busy_o;
    logic sp_push = 1'b0;
    logic sp_sel = 1'b0;
    logic [DATA_W-1:0] sp_word = 16'h0000;
    logic [DATA_W-1:0] got;
    logic [DATA_W-1:0] e;
    logic [31:0] rng = 32'h6cb9bfb3;
    logic [31:0] r0;
    logic [31:0] r1;
    logic [31:0] r2;
    int n_errors = 0;
    int checked = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    crce_top u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .scan_valid_i(scan_valid_i), .scan_data_i(scan_data_i),
        .scan_ready_o(scan_ready_o), .busy_o(busy_o));
    crce_scan_model u_scan (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .push_i(sp_push),
        .word_i(sp_word), .gap_i(4'h2), .sel_i(sp_sel), .ready_i(scan_ready_o),
        .valid_o(scan_valid_i), .data_o(scan_data_i));
    // ==========================================
    // reference and bus tasks
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic [15:0] ref_crc(input logic [15:0] acc, input logic [15:0] w,
        input logic [15:0] poly, input logic [3:0] poly_length_field, input logic [3:0] data_length_field,
        input logic dir, input logic aug);
        logic b;
        logic f;
        for (int i = 0; i <= data_length_field; i++)
        begin
            b = dir ? w[i] : w[data_length_field - i];
            f = acc[poly_length_field] ^ (aug & b);
            acc = ((acc << 1) | {15'h0000, b & !aug}) ^ (f ? (poly | 16'h0001) : 16'h0000);
        end
        return acc & (16'hffff >> (15 - poly_length_field));
    endfunction : ref_crc
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : bus_wr
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checked++;
        if (g !== x)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] x);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 got = rd_data_o;
        chk(got, x);
    endtask : rd_chk
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(posedge clk_sys_i);
        // look just past the edge so the registered flag has settled
        #1;
        while (busy_o !== 1'b0 && n < 300)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        chk({15'h0000, busy_o}, 16'h0000);
    endtask : wait_idle
    task automatic crc_run(input logic [15:0] poly, input logic [15:0] seed,
        input logic [3:0] poly_length_field, input logic [3:0] data_length_field, input logic dir, input logic aug,
        input logic [63:0] ws);
        bus_wr(OFF_CTRL, 16'h0000);
        bus_wr(OFF_POLY, poly);
        bus_wr(OFF_LEN, {8'h00, poly_length_field, data_length_field});
        bus_wr(OFF_ACC, seed);
        bus_wr(OFF_CTRL, {12'h000, aug, dir, 2'h1});
        e = seed & (16'hffff >> (15 - poly_length_field));
        for (int k = 3; k >= 0; k--)
        begin
            bus_wr(OFF_DATA, ws[k*16 +: 16]);
            e = ref_crc(e, ws[k*16 +: 16], poly, poly_length_field, data_length_field, dir, aug);
            // seed write while shifting must be dropped
            if (k == 0)
                bus_wr(OFF_ACC, 16'h1234);
            wait_idle();
        end
        rd_chk(OFF_POLY, poly & 16'hfffe);
        rd_chk(OFF_ACC, e);
    endtask : crc_run
    task automatic tally_and_finish();
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // ==========================================
    // scenarios
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rd_chk(OFF_CTRL, 16'h0000);
        rd_chk(OFF_LEN, {8'h00, POLY_LENGTH_FIELD_RST, DATA_LENGTH_FIELD_RST});
        rd_chk(OFF_ACC, ACC_RST);
        rd_chk(OFF_STAT, 16'h0000);
        bus_wr(4'hc, 16'hffff);
        rd_chk(4'hc, 16'h0000);
        crc_run(16'h8005, 16'h0000, 4'hf, 4'h7, 1'b0, 1'b1, 64'h0055006600770088);
        chk(got, 16'h32d6);
        crc_run(16'h8005, 16'h0000, 4'hf, 4'h7, 1'b1, 1'b1, 64'h0055006600770088);
        chk(got, 16'h6ba2);
        crc_run(16'hffff, 16'hffff, 4'h0, 4'h0, 1'b0, 1'b0, 64'hffff0001fffe0000);
        crc_run(16'h1021, 16'hffff, 4'hf, 4'hf, 1'b1, 1'b0, 64'h8001ffff0000a5a5);
        repeat (40)
        begin
            r0 = xs(rng);
            r1 = xs(r0);
            r2 = xs(r1);
            rng = xs(r2);
            crc_run(r0[15:0], r0[31:16], r1[3:0], r1[7:4], r1[8], r1[9], {r2, rng});
        end
        bus_wr(OFF_CTRL, 16'h000a);
        sp_sel <= 1'b1;
        bus_wr(OFF_POLY, 16'h1021);
        bus_wr(OFF_LEN, 16'h00f7);
        bus_wr(OFF_ACC, 16'hffff);
        e = 16'hffff;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk_sys_i);
            sp_push <= 1'b1;
            sp_word <= 16'h00a5 + 16'h0033 * k[15:0];
            e = ref_crc(e, 16'h00a5 + 16'h0033 * k[15:0], 16'h1021, 4'hf, 4'h7, 1'b0, 1'b1);
        end
        @(posedge clk_sys_i);
        sp_push <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        #1;
        chk({15'h0000, scan_ready_o}, 16'h0000);
        bus_wr(OFF_DATA, 16'h00ee);
        rd_chk(OFF_STAT, 16'h0006);
        bus_wr(OFF_CTRL, 16'h000b);
        repeat (100) @(posedge clk_sys_i);
        wait_idle();
        rd_chk(OFF_ACC, e);
        tally_and_finish();
    end
    initial
    begin
        repeat (60000) @(posedge clk_sys_i);
        n_errors++;
        tally_and_finish();
    end
endmodule : crce_top_test
`default_nettype wire
